// File: hdl/dbr_pkg.sv
/*
 * Shared constants for the bank, burst and refresh tracker of a DDR3-type
 * memory device: command encodings, address field positions, timing figures
 * and their cycle counts at the 250 MHz system clock.
 * Assumes a single system clock domain; the memory clock is sampled as data.
 */
// How it works
// - ACTIVE opens the row on the address bits in the bank named by BA.
// - PRECHARGE closes one bank or all; reactivation waits the precharge time.
// - Precharge to idle or precharging bank is accepted; last one restarts timing.
// - Address bit 12 picks burst in mode 00 or 01: low is chop of four, high eight beats.
// - Address bit 12 never forms part of the column address.
// - Eight beats when mode bits 1:0 are 00 or 01 and bit 12 high.
// - Write data setup or hold faults only corrupt the addressed location.
// - Write strobe faults only corrupt the addressed location; nothing hangs.
// - Refresh decodes from select, row, column strobes low and write high.
// - Refresh row comes from an internal counter; address pins ignored.
// - After refresh all banks are precharged and idle.
// - Up to eight refreshes pulled in give credit; more give none.
package dbr_pkg;

	localparam int CLK_MHZ  = 250;
	localparam int TRP_NS   = 15;
	localparam int TRFC_NS  = 110;
	localparam int TREFI_NS = 7800;

	// Least times round up, the interval rounds down
	localparam int TRP_CYC   = (TRP_NS * CLK_MHZ + 999) / 1000;
	localparam int TRFC_CYC  = (TRFC_NS * CLK_MHZ + 999) / 1000;
	localparam int TREFI_CYC = (TREFI_NS * CLK_MHZ) / 1000;

	localparam int NUM_BANKS   = 8;
	localparam int BANK_W      = 3;
	localparam int ADDR_W      = 13;
	localparam int COL_W       = 10;
	localparam int AP_BIT      = 10;
	localparam int BURST_BIT   = 12;
	localparam int CREDIT_LIM  = 8;
	localparam int CREDIT_W    = 5;
	localparam int TIMER_W     = 12;

	localparam logic [1:0] MR0_BL_RST = 2'h0;
	localparam logic [1:0] MR0_BL8    = 2'h0;
	localparam logic [1:0] MR0_OTF    = 2'h1;

	// Pin pattern {ras_n, cas_n, we_n} with select low
	localparam logic [2:0] PIN_MRS = 3'h0;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_WR  = 3'h4;
	localparam logic [2:0] PIN_RD  = 3'h5;

	typedef enum logic [2:0] {
		OP_NOP  = 3'b000,
		OP_ACT  = 3'b001,
		OP_PRE  = 3'b010,
		OP_PREA = 3'b011,
		OP_RD   = 3'b100,
		OP_WR   = 3'b101,
		OP_REF  = 3'b110,
		OP_MRS  = 3'b111
	} dbr_op_t;

	typedef enum logic [1:0] {
		ST_READY   = 2'b00,
		ST_REFRESH = 2'b01
	} dbr_state_t;

	// {op, bank, addr, burst8, autopre}
	localparam int WORD_W = 3 + BANK_W + ADDR_W + 2;

endpackage

// File: hdl/dbr_fifo.sv
/*
 * Small valid/ready buffer whose width and depth are parameters.
 * Assumes both sides on clk_sys; ce low freezes it.
 */
`timescale 1ns/1ps
`default_nettype none
module dbr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;

	wire push = ce & in_valid & in_ready;
	wire pop  = ce & out_valid & out_ready;

	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			if (push != pop)
				count <= push ? (PW+1)'(count + 1'b1) : (PW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

endmodule
`default_nettype wire

// File: hdl/dbr_core.sv
/*
 * Command side of a DDR3-type memory device: samples the command pins on
 * rising memory-clock edges, keeps per-bank open/idle state and rows,
 * precharge and refresh-cycle timing, burst selection, the internal refresh
 * row counter and the refresh credit. Decoded commands leave through a
 * two-entry buffer. Assumes the memory clock is far slower than clk_sys
 * (at least four system cycles per half period).
 */
`timescale 1ns/1ps
`default_nettype none
module dbr_core
	import dbr_pkg::*;
#(
	parameter int TRP_CYCLES   = TRP_CYC,
	parameter int TRFC_CYCLES  = TRFC_CYC,
	parameter int TREFI_CYCLES = TREFI_CYC,
	parameter int BUF_DEPTH    = 2
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire logic                  mem_ck,
	input  wire logic                  cs_n,
	input  wire logic                  ras_n,
	input  wire logic                  cas_n,
	input  wire logic                  we_n,
	input  wire logic [BANK_W-1:0]     ba,
	input  wire logic [ADDR_W-1:0]     addr,
	output logic                       cmd_valid,
	input  wire logic                  cmd_ready,
	output logic      [2:0]            cmd_op,
	output logic      [BANK_W-1:0]     cmd_bank,
	output logic      [ADDR_W-1:0]     cmd_addr,
	output logic                       cmd_burst8,
	output logic                       cmd_autopre,
	output logic      [NUM_BANKS-1:0]  bank_open,
	output logic      [ADDR_W-1:0]     refresh_row,
	output logic signed [CREDIT_W-1:0] refresh_credit,
	output logic                       refresh_busy,
	output logic                       timing_error,
	output logic                       cmd_overrun
);

	// Two-stage synchronisers for every pin
	localparam int PIN_W = 1 + 4 + BANK_W + ADDR_W;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic             ck_prev;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1  <= '0;
			pin_s2  <= '0;
			ck_prev <= 1'b0;
		end else if (ce) begin
			pin_s1  <= {mem_ck, cs_n, ras_n, cas_n, we_n, ba, addr};
			pin_s2  <= pin_s1;
			ck_prev <= pin_s2[PIN_W-1];
		end
	end

	wire                ck_s       = pin_s2[PIN_W-1];
	wire                cs_s_n     = pin_s2[PIN_W-2];
	wire [2:0]          pat_s      = pin_s2[PIN_W-3 -: 3];
	wire [BANK_W-1:0]   ba_s       = pin_s2[ADDR_W +: BANK_W];
	wire [ADDR_W-1:0]   addr_s     = pin_s2[ADDR_W-1:0];
	wire                ck_rise    = ce & ck_s & ~ck_prev;

	// Command decode on the sampled rising edge
	wire is_sel   = ~cs_s_n;
	wire dec_ref  = is_sel & (pat_s == PIN_REF);
	wire dec_act  = is_sel & (pat_s == PIN_ACT);
	wire dec_pre  = is_sel & (pat_s == PIN_PRE);
	wire dec_rd   = is_sel & (pat_s == PIN_RD);
	wire dec_wr   = is_sel & (pat_s == PIN_WR);
	wire dec_mrs  = is_sel & (pat_s == PIN_MRS) & (ba_s == '0);
	wire pre_all  = dec_pre & addr_s[AP_BIT];
	wire any_cmd  = is_sel & (pat_s != 3'h7);

	dbr_op_t dec_op;
	assign dec_op = dec_act ? OP_ACT :
			dec_pre ? (pre_all ? OP_PREA : OP_PRE) :
			dec_rd  ? OP_RD :
			dec_wr  ? OP_WR :
			dec_ref ? OP_REF :
			dec_mrs ? OP_MRS : OP_NOP;

	// Burst selection; bit 12 leaves the column field
	logic [1:0] mr0_bl;
	wire        bl_otf   = (mr0_bl == MR0_BL8) | (mr0_bl == MR0_OTF);
	wire        burst8   = bl_otf & addr_s[BURST_BIT];
	wire [ADDR_W-1:0] col_s = ADDR_W'(addr_s[COL_W-1:0]);

	// Per-bank state and precharge timers
	logic [ADDR_W-1:0]  open_row [NUM_BANKS];
	logic [TIMER_W-1:0] trp_cnt  [NUM_BANKS];
	logic [NUM_BANKS-1:0] trp_busy;
	logic [NUM_BANKS-1:0] bank_sel;

	assign bank_sel = NUM_BANKS'(1) << ba_s;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			assign trp_busy[gi] = (trp_cnt[gi] != '0);
		end
	endgenerate

	wire sel_open  = |(bank_open & bank_sel);
	wire sel_trp   = |(trp_busy & bank_sel);
	wire all_quiet = (bank_open == '0) & (trp_busy == '0);

	// Refresh cycle timing
	dbr_state_t         state;
	logic [TIMER_W-1:0] trfc_cnt;
	logic [TIMER_W-1:0] refi_cnt;
	wire                tick_due = ce & (refi_cnt == '0);

	assign refresh_busy = (state == ST_REFRESH);

	// Protocol faults; decoding continues regardless
	wire err_act = dec_act & (sel_open | sel_trp);
	wire err_rw  = (dec_rd | dec_wr) & ~sel_open;
	wire err_ref = dec_ref & ~all_quiet;
	wire err_rfc = refresh_busy & any_cmd;
	wire err_pp  = tick_due & (refresh_credit == CREDIT_W'(CREDIT_LIM));
	wire err_now = ck_rise & (err_act | err_rw | err_ref | err_rfc);

	// Sticky until reset, since recovery needs full reinitialisation
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			timing_error <= 1'b0;
		else if (ce & (err_now | err_pp))
			timing_error <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			mr0_bl <= MR0_BL_RST;
		else if (ck_rise & dec_mrs & ~refresh_busy)
			mr0_bl <= addr_s[1:0];
	end

	// Faulty write data only affects the array, never this state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bank_open <= '0;
			for (int b = 0; b < NUM_BANKS; b++)
				trp_cnt[b] <= '0;
		end else if (ce) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				if (ck_rise & (pre_all | (dec_pre & bank_sel[b]))) begin
					bank_open[b] <= 1'b0;
					trp_cnt[b]   <= TIMER_W'(TRP_CYCLES);
				end else begin
					if (ck_rise & dec_act & bank_sel[b] & ~err_act)
						bank_open[b] <= 1'b1;
					else if (ck_rise & (dec_rd | dec_wr) & bank_sel[b]
						& addr_s[AP_BIT] & bank_open[b])
						bank_open[b] <= 1'b0;
					else if (state == ST_REFRESH)
						bank_open[b] <= 1'b0;
					if (trp_busy[b])
						trp_cnt[b] <= TIMER_W'(trp_cnt[b] - 1'b1);
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int b = 0; b < NUM_BANKS; b++)
			if (ce & ck_rise & dec_act & bank_sel[b] & ~err_act)
				open_row[b] <= addr_s;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_READY;
			trfc_cnt <= '0;
		end else if (ce) begin
			unique case (state)
				ST_READY: begin
					if (ck_rise & dec_ref) begin
						state    <= ST_REFRESH;
						// Busy one edge short, so a command a full tRFC later passes
						trfc_cnt <= TIMER_W'(TRFC_CYCLES - 2);
					end
				end
				ST_REFRESH: begin
					if (trfc_cnt == '0)
						state <= ST_READY;
					else
						trfc_cnt <= TIMER_W'(trfc_cnt - 1'b1);
				end
			endcase
		end
	end

	// Internal refresh row counter, address pins play no part
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			refresh_row <= '0;
		else if (ck_rise & dec_ref & ~refresh_busy)
			refresh_row <= ADDR_W'(refresh_row + 1'b1);
	end

	// Refresh credit: positive is owed, negative is pulled in
	wire ref_taken = ck_rise & dec_ref & ~refresh_busy;
	wire at_floor  = (refresh_credit == -CREDIT_W'(CREDIT_LIM));
	wire at_ceil   = (refresh_credit == CREDIT_W'(CREDIT_LIM + 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			refi_cnt       <= TIMER_W'(TREFI_CYCLES - 1);
			refresh_credit <= '0;
		end else if (ce) begin
			refi_cnt <= tick_due ? TIMER_W'(TREFI_CYCLES - 1)
					     : TIMER_W'(refi_cnt - 1'b1);
			if (tick_due & ~ref_taken & ~at_ceil)
				refresh_credit <= refresh_credit + CREDIT_W'(1);
			else if (ref_taken & ~tick_due & ~at_floor)
				refresh_credit <= refresh_credit - CREDIT_W'(1);
		end
	end

	// Hold stage ahead of the buffer; a word waits here while it is full
	logic              hold_valid;
	logic [WORD_W-1:0] hold_word;
	logic              buf_ready;
	logic [WORD_W-1:0] buf_word;
	wire               take     = ce & hold_valid & buf_ready;
	wire               new_word = ck_rise & (dec_op != OP_NOP);
	wire [ADDR_W-1:0]  word_addr = (dec_rd | dec_wr) ? col_s : addr_s;
	wire               word_ap   = (dec_rd | dec_wr) & addr_s[AP_BIT];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hold_valid  <= 1'b0;
			hold_word   <= '0;
			cmd_overrun <= 1'b0;
		end else if (ce) begin
			if (new_word & hold_valid & ~take)
				cmd_overrun <= 1'b1;
			if (new_word & (~hold_valid | take)) begin
				hold_valid <= 1'b1;
				hold_word  <= {dec_op, ba_s, word_addr, burst8, word_ap};
			end else if (take) begin
				hold_valid <= 1'b0;
			end
		end
	end

	dbr_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (hold_valid),
		.in_ready  (buf_ready),
		.in_data   (hold_word),
		.out_valid (cmd_valid),
		.out_ready (cmd_ready),
		.out_data  (buf_word)
	);

	assign cmd_op      = buf_word[WORD_W-1 -: 3];
	assign cmd_bank    = buf_word[WORD_W-4 -: BANK_W];
	assign cmd_addr    = buf_word[2 +: ADDR_W];
	assign cmd_burst8  = buf_word[1];
	assign cmd_autopre = buf_word[0];

endmodule
`default_nettype wire

// File: tb/dbr_core_checker.sv
/* Concurrent checks on the ports of dbr_core, bound after the module.
   Assumes one clk_sys domain with asynchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module dbr_core_checker
	import dbr_pkg::*;
#(
	parameter int TRFC_CYCLES = TRFC_CYC
) (
	input wire logic                       clk_sys,
	input wire logic                       rst_n,
	input wire logic                       cmd_valid,
	input wire logic                       cmd_ready,
	input wire logic [2:0]                 cmd_op,
	input wire logic [BANK_W-1:0]          cmd_bank,
	input wire logic [ADDR_W-1:0]          cmd_addr,
	input wire logic                       cmd_burst8,
	input wire logic                       cmd_autopre,
	input wire logic [NUM_BANKS-1:0]       bank_open,
	input wire logic [ADDR_W-1:0]          refresh_row,
	input wire logic signed [CREDIT_W-1:0] refresh_credit,
	input wire logic                       refresh_busy,
	input wire logic                       timing_error,
	input wire logic                       cmd_overrun
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [7:0] busy_len;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			busy_len <= 8'h00;
		else
			busy_len <= refresh_busy ? busy_len + 8'h01 : 8'h00;
	end
	property p_word_hold;
		cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_op, cmd_bank, cmd_addr, cmd_burst8, cmd_autopre});
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("command word moved while stalled");
	property p_col_no_a12;
		cmd_valid && (cmd_op == OP_RD || cmd_op == OP_WR) |-> cmd_addr[12:10] == 3'h0;
	endproperty
	a_col_no_a12: assert property (p_col_no_a12)
		else $error("column carries upper address bits");
	property p_ref_idle;
		$rose(refresh_busy) && !timing_error |-> bank_open == 8'h00;
	endproperty
	a_ref_idle: assert property (p_ref_idle)
		else $error("bank open during refresh");
	property p_trfc;
		$fell(refresh_busy) |-> busy_len >= TRFC_CYCLES - 1 && busy_len <= TRFC_CYCLES + 1;
	endproperty
	a_trfc: assert property (p_trfc)
		else $error("refresh cycle length wrong");
	property p_row_step;
		$changed(refresh_row) |-> $rose(refresh_busy) && refresh_row == $past(refresh_row) + 13'h1;
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("refresh row moved without refresh");
	property p_credit_range;
		refresh_credit >= -5'sd8 && refresh_credit <= 5'sd9;
	endproperty
	a_credit_range: assert property (p_credit_range)
		else $error("refresh credit out of range");
	property p_credit_step;
		$changed(refresh_credit) |-> refresh_credit == $past(refresh_credit) + 5'sd1
			|| refresh_credit == $past(refresh_credit) - 5'sd1;
	endproperty
	a_credit_step: assert property (p_credit_step)
		else $error("refresh credit jumped");
	property p_err_sticky;
		timing_error |=> timing_error;
	endproperty
	a_err_sticky: assert property (p_err_sticky)
		else $error("timing error cleared");
	property p_overrun_sticky;
		!$fell(cmd_overrun);
	endproperty
	a_overrun_sticky: assert property (p_overrun_sticky)
		else $error("overrun flag cleared");
	c_overrun: cover property ($rose(cmd_overrun));
endmodule
bind dbr_core dbr_core_checker #(.TRFC_CYCLES(TRFC_CYCLES)) u_chk (.clk_sys(clk_sys),
	.rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
	.cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_burst8(cmd_burst8),
	.cmd_autopre(cmd_autopre), .bank_open(bank_open), .refresh_row(refresh_row),
	.refresh_credit(refresh_credit), .refresh_busy(refresh_busy),
	.timing_error(timing_error), .cmd_overrun(cmd_overrun));
`default_nettype wire

// File: tb/dbr_ctrl_model.sv
/* Memory controller pin driver: one memory clock cycle per command.
   Assumes clk_sys at 4 ns; back to back, the memory clock runs 8 system cycles (32 ns). */
`timescale 1ns/1ps
`default_nettype none
module dbr_ctrl_model
	import dbr_pkg::*;
(
	input wire logic          clk_sys,
	output logic              mem_ck,
	output logic              cs_n,
	output logic              ras_n,
	output logic              cas_n,
	output logic              we_n,
	output logic [BANK_W-1:0] ba,
	output logic [ADDR_W-1:0] addr
);
	initial begin
		mem_ck = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 3'h0;
		addr = 13'h0000;
	end
	// Pins stand 3 cycles before and 4 after the rise; clock low between commands
	task automatic send(input logic [2:0] pins, input logic [BANK_W-1:0] b,
			input logic [ADDR_W-1:0] a);
		@(negedge clk_sys);
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = pins;
		ba = b;
		addr = a;
		repeat (3) @(negedge clk_sys);
		mem_ck = 1'b1;
		repeat (4) @(negedge clk_sys);
		mem_ck = 1'b0;
		cs_n = 1'b1;
		ba = ~b;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/* Self-checking bench for dbr_core with random legal command traffic.
   Assumes the controller model in dbr_ctrl_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dbr_pkg::*;
;
	logic                       clk_sys = 1'b0;
	logic                       rst_n = 1'b0;
	logic                       cmd_ready = 1'b0;
	logic                       stall = 1'b1;
	logic                       sb_on = 1'b1;
	logic                       ce = 1'b1;
	wire logic                  mem_ck, cs_n, ras_n, cas_n, we_n;
	wire logic [BANK_W-1:0]     ba;
	wire logic [ADDR_W-1:0]     addr;
	logic                       cmd_valid, cmd_burst8, cmd_autopre;
	logic [2:0]                 cmd_op;
	logic [BANK_W-1:0]          cmd_bank;
	logic [ADDR_W-1:0]          cmd_addr, refresh_row;
	logic [NUM_BANKS-1:0]       bank_open;
	logic signed [CREDIT_W-1:0] refresh_credit;
	logic                       refresh_busy, timing_error, cmd_overrun;
	int                         fail_count = 0;
	int                         cmp_count = 0;
	logic [WORD_W:0]            exp_q[$];
	logic [NUM_BANKS-1:0]       exp_open = 8'h00;
	logic [1:0]                 mode = 2'h0;
	initial forever #2 clk_sys = ~clk_sys;
	dbr_ctrl_model ctrl (.clk_sys(clk_sys), .mem_ck(mem_ck), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
	dbr_core #(.TRFC_CYCLES(8), .TREFI_CYCLES(64)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.ce(ce), .mem_ck(mem_ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_burst8(cmd_burst8),
		.cmd_autopre(cmd_autopre), .bank_open(bank_open), .refresh_row(refresh_row),
		.refresh_credit(refresh_credit), .refresh_busy(refresh_busy),
		.timing_error(timing_error), .cmd_overrun(cmd_overrun));
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic exp_b8(logic [1:0] m, logic a12);
		return (m <= 2'h1) && a12;
	endfunction
	task automatic issue(dbr_op_t op, logic [2:0] b, logic [12:0] a);
		logic [2:0] pins;
		logic       rw;
		rw = (op == OP_RD || op == OP_WR);
		case (op)
			OP_ACT: pins = PIN_ACT;
			OP_PRE, OP_PREA: pins = PIN_PRE;
			OP_RD: pins = PIN_RD;
			OP_WR: pins = PIN_WR;
			OP_REF: pins = PIN_REF;
			default: pins = PIN_MRS;
		endcase
		if (op == OP_PRE || op == OP_PREA)
			a[AP_BIT] = (op == OP_PREA);
		exp_q.push_back({rw, op, b, rw ? {3'h0, a[9:0]} : a, exp_b8(mode, a[12]), a[10]});
		ctrl.send(pins, b, a);
		if (op == OP_ACT) exp_open[b] = 1'b1;
		if (op == OP_PRE || (rw && a[AP_BIT])) exp_open[b] = 1'b0;
		if (op == OP_PREA) exp_open = 8'h00;
		if (op == OP_MRS) mode = a[1:0];
		check("bank_open", bank_open, exp_open);
	endtask
	always @(negedge clk_sys) cmd_ready <= !stall && ($urandom % 4 != 0);
	always @(posedge clk_sys) begin
		logic [WORD_W:0] e;
		if (rst_n && sb_on && ce && cmd_valid && cmd_ready) begin
			e = exp_q.pop_front();
			check("cmd_op", cmd_op, e[20:18]);
			check("cmd_bank", cmd_bank, e[17:15]);
			check("cmd_addr", cmd_addr, e[14:2]);
			if (e[21]) check("cmd_burst8", cmd_burst8, e[1]);
			if (e[21]) check("cmd_autopre", cmd_autopre, e[0]);
		end
	end
	initial begin
		#20000;
		fail_count++;
		complete_run();
	end
	initial begin
		dbr_op_t op;
		logic [2:0] b;
		int r;
		logic signed [CREDIT_W-1:0] cr;
		void'($urandom(49));
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		stall = 1'b0;
		repeat (4) @(negedge clk_sys);
		// More pulled-in refreshes than the credit can hold
		for (int i = 0; i < 16; i++) issue(OP_REF, 3'($urandom), 13'($urandom));
		check("credit_floor", refresh_credit <= -5'sd7, 1'b1);
		check("refresh_row", refresh_row, 32'd16);
		issue(OP_ACT, 3'h0, 13'h1fff);
		issue(OP_RD, 3'h0, 13'h1fff);
		issue(OP_ACT, 3'h0, 13'h0000);
		issue(OP_WR, 3'h0, 13'h0000);
		for (int m = 0; m < 4; m++) begin
			issue(OP_MRS, 3'h0, 13'(m));
			for (int i = 0; i < 12; i++) begin
				b = 3'($urandom);
				r = $urandom % 4;
				stall = (i == 6 || i == 7);
				// Only open banks see reads and writes
				op = exp_open[b] ? (r == 0 ? OP_PRE : r[0] ? OP_RD : OP_WR)
					: (r == 0 ? OP_PRE : OP_ACT);
				issue(op, b, 13'($urandom));
			end
			issue(OP_PREA, 3'($urandom), 13'($urandom));
			issue(OP_REF, 3'($urandom), 13'($urandom));
		end
		check("timing_error", timing_error, 1'b0);
		// Let the last refresh finish, then freeze everything
		repeat (8) @(negedge clk_sys);
		cr = refresh_credit;
		ce = 1'b0;
		repeat (200) @(negedge clk_sys);
		check("ce_freeze", refresh_credit, cr);
		ce = 1'b1;
		// Postpone beyond the limit
		repeat (64 * 16) @(negedge clk_sys);
		check("credit_ceiling", refresh_credit, 5'sd9);
		check("timing_error", timing_error, 1'b1);
		stall = 1'b1;
		for (int i = 0; i < 5; i++) issue(OP_PRE, 3'(i), 13'h0000);
		check("cmd_overrun", cmd_overrun, 1'b1);
		check("cmd_valid", cmd_valid, 1'b1);
		sb_on = 1'b0;
		stall = 1'b0;
		repeat (20) @(negedge clk_sys);
		check("cmd_valid", cmd_valid, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
